// ---- logic/pfu_params.svh ----
`ifndef PFU_PARAMS_SVH
`define PFU_PARAMS_SVH
// register byte offsets
`define PFU_CTRL_OFS      12'h000
`define PFU_STAT_OFS      12'h004
// control field positions
`define PFU_FMT_LSB       0
`define PFU_FMT_MSB       2
`define PFU_GAMMA_BIT     3
`define PFU_BLUE_BIT      4
`define PFU_OVM_LSB       5
`define PFU_OVM_MSB       6
`define PFU_CTRL_RST      7'h00
// blue field, as Y, Cb, Cr
`define PFU_BLUE_Y        8'h23
`define PFU_BLUE_CB       8'hD4
`define PFU_BLUE_CR       8'h72
// timing reference preamble
`define PFU_TRS_FIRST     8'hFF
`define PFU_TRS_SKIP      2'h3
`endif

// ---- logic/pfu_pkg.sv ----
package pfu_pkg;
  typedef enum logic [2:0] {
    PFU_YC16, PFU_YC8, PFU_EMB8, PFU_RGB16, PFU_RGB24
  } pfu_fmt_t;
  typedef enum logic [1:0] {
    PFU_OV_OFF, PFU_OV_EXT, PFU_OV_INT, PFU_OV_HARD
  } pfu_ovm_t;
endpackage : pfu_pkg

// ---- logic/pfu_unpacker.sv ----
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "pfu_params.svh"
// Summary of operation
// RQ1: bus bit meaning follows software-selected format
// RQ2: every format becomes 4:4:4 luma/chroma samples
// RQ3: single clock at twice pixel rate
// RQ4: 4:2:2 samples 0-255, passed unclipped
// RQ5: chroma lane alternates Cb then Cr
// RQ6: 16-bit: luma bits 8-15, chroma 0-7
// RQ7: 8-bit: interleaved on bits 8-15 only
// RQ8: embedded sync: skip codes, overlay from 16-20
// RQ9: 24-bit RGB: blue low, green mid, red high
// RQ10: 565 RGB left-shifted to 8-bit scale
// RQ11: optional gamma on linear RGB input
// RQ12: 5-bit overlay: color select, mix level
// RQ13: blue screen ignores bus, overlay still applies; in embedded sync an FF on bits 8-15 still restarts seq, pausing pixels
// RQ14: overlay select zero passes pixel unchanged
// RQ15: no overlay in 24-bit RGB format
// RQ16: 8-bit order Cb,Y,Cr,Y; chroma shared by two
module pfu_unpacker (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // video source pins
  input  wire logic [23:0] pixel_input_bus,
  input  wire logic [2:0]  overlay_color_select,
  input  wire logic        overlay_mix_level_lsb,
  input  wire logic        overlay_mix_level_msb,
  // 4:4:4 output
  output logic      [7:0]  y_out,
  output logic      [7:0]  cb_out,
  output logic      [7:0]  cr_out,
  output logic             pixel_valid
);

  function automatic logic [7:0] gamma(input logic [7:0] x);
    // three-segment concave curve; cheap stand-in for a true power law
    if (x < 8'h10) gamma = {x[5:0], 2'h0};
    else if (x < 8'h40) gamma = 8'h40 + {x[6:0] - 7'h10, 1'h0};
    else gamma = 8'hA0 + {1'h0, x[7:1]} - 8'h20;
  endfunction : gamma

  function automatic logic [23:0] csc(input logic [7:0] r, input logic [7:0] g,
                                      input logic [7:0] b);
    logic signed [17:0] sy;
    logic signed [17:0] sb;
    logic signed [17:0] sr;
    sy = 18'sd66 * $signed({10'h0, r}) + 18'sd129 * $signed({10'h0, g})
       + 18'sd25 * $signed({10'h0, b}) + 18'sd4224;
    sb = 18'sd112 * $signed({10'h0, b}) - 18'sd38 * $signed({10'h0, r})
       - 18'sd74 * $signed({10'h0, g}) + 18'sd32896;
    sr = 18'sd112 * $signed({10'h0, r}) - 18'sd94 * $signed({10'h0, g})
       - 18'sd18 * $signed({10'h0, b}) + 18'sd32896;
    csc = {sy[15:8], sb[15:8], sr[15:8]};
  endfunction : csc

  function automatic logic [23:0] palette(input logic [2:0] sel);
    unique case (sel)
      3'h1: palette = {8'h23, 8'hD4, 8'h72};
      3'h2: palette = {8'h3F, 8'h66, 8'hF0};
      3'h3: palette = {8'h54, 8'hC2, 8'hCE};
      3'h4: palette = {8'h90, 8'h36, 8'h22};
      3'h5: palette = {8'hA5, 8'h9A, 8'h10};
      3'h6: palette = {8'hA2, 8'h2C, 8'h8E};
      3'h7: palette = {8'hEB, 8'h80, 8'h80};
      default: palette = {8'h00, 8'h80, 8'h80};
    endcase
  endfunction : palette

  function automatic logic [7:0] mix8(input logic [7:0] ov, input logic [7:0] px,
                                      input logic [3:0] k);
    logic [11:0] s;
    s = {4'h0, ov} * {8'h0, k} + {4'h0, px} * {8'h0, 4'h8 - k};
    mix8 = s[10:3];
  endfunction : mix8

  // registers
  logic [6:0]  ctrl;
  logic [15:0] pix_count;
  logic        txn_done;
  logic        hit_ctrl;
  logic        hit_stat;
  assign txn_done = psel & penable & pready;
  assign hit_ctrl = (paddr == `PFU_CTRL_OFS);
  assign hit_stat = (paddr == `PFU_STAT_OFS);

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit_ctrl & ~hit_stat;
      prdata  <= (psel & penable & ~pready & ~pwrite)
                 ? (hit_ctrl ? {25'h0, ctrl} : hit_stat ? {16'h0, pix_count} : 32'h0)
                 : 32'h0;
    end
  end

  logic ctrl_wr;
  assign ctrl_wr = txn_done & pwrite & hit_ctrl;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) ctrl <= `PFU_CTRL_RST;
    else if (ctrl_wr) ctrl <= pwdata[6:0]; // RQ1
  end

  wire pfu_pkg::pfu_fmt_t fmt = (ctrl[`PFU_FMT_MSB:`PFU_FMT_LSB] > 3'h4) ? pfu_pkg::PFU_YC16
                              : pfu_pkg::pfu_fmt_t'(ctrl[`PFU_FMT_MSB:`PFU_FMT_LSB]);
  wire pfu_pkg::pfu_ovm_t ovm = pfu_pkg::pfu_ovm_t'(ctrl[`PFU_OVM_MSB:`PFU_OVM_LSB]);
  wire gamma_en = ctrl[`PFU_GAMMA_BIT];
  wire blue_en  = ctrl[`PFU_BLUE_BIT];

  // pins come from the source's clock, so two flops first
  logic [23:0] pix_s1;
  logic [23:0] pix;
  logic [4:0]  ovl_s1;
  logic [4:0]  ovl_pin;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pix_s1  <= 24'h0;
      pix     <= 24'h0;
      ovl_s1  <= 5'h0;
      ovl_pin <= 5'h0;
    end else begin
      pix_s1  <= pixel_input_bus;
      pix     <= pix_s1;
      ovl_s1  <= {overlay_mix_level_msb, overlay_mix_level_lsb, overlay_color_select};
      ovl_pin <= ovl_s1;
    end
  end

  // slot counters; a control write restarts the sequence
  logic [1:0] seq;
  logic [1:0] skip;
  logic       chroma_cr;
  wire        byte_fmt = (fmt == pfu_pkg::PFU_YC8) || (fmt == pfu_pkg::PFU_EMB8);
  wire [7:0]  lane = pix[15:8];
  wire        trs_start = (fmt == pfu_pkg::PFU_EMB8) && (lane == `PFU_TRS_FIRST)
                          && (skip == 2'h0);
  wire        byte_ok = byte_fmt && !blue_en && (skip == 2'h0) && !trs_start;
  wire        wide_slot = !byte_fmt && seq[0]; // RQ3

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      seq  <= 2'h0;
      skip <= 2'h0;
    end else if (ctrl_wr) begin
      seq  <= 2'h0;
      skip <= 2'h0;
    end else if (trs_start) begin
      seq  <= 2'h0;
      skip <= `PFU_TRS_SKIP; // RQ8
    end else begin
      skip <= (skip != 2'h0) ? skip - 2'h1 : 2'h0;
      seq  <= (skip != 2'h0) ? 2'h0 : seq + 2'h1;
    end
  end

  // rgb lanes
  wire [7:0] r_raw = (fmt == pfu_pkg::PFU_RGB24) ? pix[23:16] : {pix[15:11], 3'h0}; // RQ9 RQ10
  wire [7:0] g_raw = (fmt == pfu_pkg::PFU_RGB24) ? pix[15:8] : {pix[10:5], 2'h0};
  wire [7:0] b_raw = (fmt == pfu_pkg::PFU_RGB24) ? pix[7:0] : {pix[4:0], 3'h0};
  wire [23:0] rgb_ycc = gamma_en ? csc(gamma(r_raw), gamma(g_raw), gamma(b_raw)) // RQ11
                                 : csc(r_raw, g_raw, b_raw);
  wire [4:0] ovl_src = (fmt == pfu_pkg::PFU_EMB8) ? pix[20:16] : ovl_pin; // RQ8

  // 4:2:2 holding registers
  logic [7:0] hold_cb;
  logic [7:0] hold_cr;
  logic [7:0] hold_y;
  logic       y_pend;
  logic [7:0] s1_y;
  logic [7:0] s1_cb;
  logic [7:0] s1_cr;
  logic [4:0] s1_ovl;
  logic       s1_vld;
  logic [7:0] next_s1_y;
  logic [7:0] next_s1_cb;
  logic [7:0] next_s1_cr;
  logic       next_s1_vld;

  // chroma is repeated across the luma pair, no interpolation
  always_comb begin
    next_s1_y   = s1_y;
    next_s1_cb  = s1_cb;
    next_s1_cr  = s1_cr;
    next_s1_vld = 1'b0;
    if (blue_en) begin
      next_s1_vld = seq[0]; // RQ13
      next_s1_y   = `PFU_BLUE_Y;
      next_s1_cb  = `PFU_BLUE_CB;
      next_s1_cr  = `PFU_BLUE_CR;
    end else if (byte_ok && (seq == 2'h2)) begin
      next_s1_vld = 1'b1; // RQ16 RQ7
      next_s1_y   = hold_y;
      next_s1_cb  = hold_cb;
      next_s1_cr  = lane;
    end else if (byte_ok && (seq == 2'h0)) begin
      // second luma waits for the next Cb slot, so pixels stay two clocks apart
      next_s1_vld = y_pend; // RQ16
      next_s1_y   = hold_y;
      next_s1_cb  = hold_cb;
      next_s1_cr  = hold_cr;
    end else if (wide_slot && (fmt == pfu_pkg::PFU_YC16)) begin
      next_s1_vld = chroma_cr | y_pend; // RQ6
      next_s1_y   = chroma_cr ? hold_y : hold_y;
      next_s1_cb  = hold_cb;
      next_s1_cr  = chroma_cr ? pix[7:0] : hold_cr;
    end else if (wide_slot) begin
      next_s1_vld = 1'b1; // RQ2
      {next_s1_y, next_s1_cb, next_s1_cr} = rgb_ycc;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hold_cb   <= 8'h80;
      hold_cr   <= 8'h80;
      hold_y    <= 8'h0;
      y_pend    <= 1'b0;
      chroma_cr <= 1'b0;
    end else if (ctrl_wr) begin
      y_pend    <= 1'b0;
      chroma_cr <= 1'b0;
    end else if (byte_ok) begin
      if (seq == 2'h0) hold_cb <= lane; // RQ5
      if (seq[0]) hold_y <= lane;
      if (seq == 2'h2) hold_cr <= lane;
      y_pend <= (seq == 2'h3);
    end else if (wide_slot && (fmt == pfu_pkg::PFU_YC16)) begin
      chroma_cr <= ~chroma_cr; // RQ5
      hold_y    <= pix[15:8]; // RQ4
      y_pend    <= 1'b1;
      if (chroma_cr) hold_cr <= pix[7:0];
      else hold_cb <= pix[7:0];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s1_y   <= 8'h0;
      s1_cb  <= 8'h80;
      s1_cr  <= 8'h80;
      s1_vld <= 1'b0;
      s1_ovl <= 5'h0;
    end else begin
      s1_y   <= next_s1_y;
      s1_cb  <= next_s1_cb;
      s1_cr  <= next_s1_cr;
      s1_vld <= next_s1_vld;
      s1_ovl <= blue_en ? ovl_pin : ovl_src; // RQ12
    end
  end

  // overlay weight in eighths
  wire       ov_off = (ovm == pfu_pkg::PFU_OV_OFF) || (s1_ovl[2:0] == 3'h0) // RQ14
                      || (fmt == pfu_pkg::PFU_RGB24); // RQ15
  wire [3:0] ext_k = s1_ovl[4] ? (s1_ovl[3] ? 4'h8 : 4'h7) : (s1_ovl[3] ? 4'h1 : 4'h0);
  wire [3:0] ov_k = ov_off ? 4'h0 : (ovm == pfu_pkg::PFU_OV_EXT) ? ext_k : 4'h8; // RQ12
  wire [23:0] ov_ycc = palette(s1_ovl[2:0]);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      y_out       <= 8'h0;
      cb_out      <= 8'h80;
      cr_out      <= 8'h80;
      pixel_valid <= 1'b0;
      pix_count   <= 16'h0;
    end else begin
      pixel_valid <= s1_vld;
      if (s1_vld) begin
        y_out     <= mix8(ov_ycc[23:16], s1_y, ov_k);
        cb_out    <= mix8(ov_ycc[15:8], s1_cb, ov_k);
        cr_out    <= mix8(ov_ycc[7:0], s1_cr, ov_k);
        pix_count <= pix_count + 16'h1;
      end
    end
  end

  property p_ready_pulse;
    @(posedge clock) disable iff (!resetn) pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held two cycles");

  property p_ctrl_write;
    @(posedge clock) disable iff (!resetn) ctrl_wr |=> ctrl == $past(pwdata[6:0]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost"); // RQ1

  property p_rate;
    @(posedge clock) disable iff (!resetn) pixel_valid |=> !pixel_valid;
  endproperty
  a_rate: assert property (p_rate) else $error("pixel faster than half clock"); // RQ3

  property p_zero_pass;
    @(posedge clock) disable iff (!resetn)
      s1_vld && s1_ovl[2:0] == 3'h0 |=> y_out == $past(s1_y) && cr_out == $past(s1_cr);
  endproperty
  a_zero_pass: assert property (p_zero_pass) else $error("select zero altered pixel"); // RQ14

  property p_rgb24_plain;
    @(posedge clock) disable iff (!resetn)
      s1_vld && fmt == pfu_pkg::PFU_RGB24 && !ctrl_wr |=> cb_out == $past(s1_cb);
  endproperty
  a_rgb24_plain: assert property (p_rgb24_plain) else $error("overlay in 24-bit rgb"); // RQ15

  property p_blue;
    @(posedge clock) disable iff (!resetn)
      blue_en && seq[0] && !ctrl_wr ##1 s1_ovl[2:0] == 3'h0 |=> cb_out == `PFU_BLUE_CB;
  endproperty
  a_blue: assert property (p_blue) else $error("blue field wrong"); // RQ13

  property p_byte_cr;
    @(posedge clock) disable iff (!resetn)
      byte_ok && seq == 2'h2 |=> s1_vld && s1_cr == $past(lane) ##1 s1_cr == $past(s1_cr);
  endproperty
  a_byte_cr: assert property (p_byte_cr) else $error("8-bit chroma pairing wrong"); // RQ16

  property p_trs_skip;
    @(posedge clock) disable iff (!resetn)
      trs_start && !ctrl_wr |=> skip == 2'h3 ##1 skip == 2'h2 ##1 skip == 2'h1;
  endproperty
  a_trs_skip: assert property (p_trs_skip) else $error("timing code not skipped"); // RQ8

  // pending luma of a pair must leave on the following Cb slot
  property p_byte_y1;
    @(posedge clock) disable iff (!resetn)
      byte_ok && seq == 2'h3 && !ctrl_wr ##1 byte_ok && seq == 2'h0
        |=> s1_vld && s1_y == $past(hold_y);
  endproperty
  a_byte_y1: assert property (p_byte_y1) else $error("second luma lost"); // RQ16

  // full weight on color one must give the blue palette entry
  property p_ext_full;
    @(posedge clock) disable iff (!resetn)
      s1_vld && ovm == pfu_pkg::PFU_OV_EXT && fmt != pfu_pkg::PFU_RGB24 && s1_ovl == 5'h19
        |=> y_out == `PFU_BLUE_Y && cr_out == `PFU_BLUE_CR;
  endproperty
  a_ext_full: assert property (p_ext_full) else $error("full overlay weight wrong"); // RQ12

  c_byte_y1: cover property (@(posedge clock) byte_ok && seq == 2'h0 && y_pend);
  c_rgb16: cover property (@(posedge clock) fmt == pfu_pkg::PFU_RGB16 && pixel_valid);
  c_emb: cover property (@(posedge clock) trs_start);
  c_ext_mix: cover property (@(posedge clock) s1_vld && ov_k == 4'h7);
endmodule : pfu_unpacker

// ---- verification/pfu_source.sv ----
`timescale 1ns/1ps
module pfu_source (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // pattern select
  input  wire logic        stream,
  input  wire logic [23:0] word,
  // video bus
  output logic      [23:0] pixel_input_bus
);
  logic [1:0] phase;
  logic       in_data;
  logic [7:0] junk;
  logic [7:0] lane;

  // restarts with a timing code each time streaming begins
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      phase   <= 2'h0;
      in_data <= 1'b0;
      junk    <= 8'h00;
    end else begin
      junk  <= junk + 8'h35;
      phase <= stream ? phase + 2'h1 : 2'h0;
      if (!stream) begin
        in_data <= 1'b0;
      end else if (phase == 2'h3) begin
        in_data <= 1'b1;
      end
    end
  end

  assign lane = !in_data ? (phase == 2'h0 ? 8'hFF : phase == 2'h3 ? 8'h80 : 8'h00) :
                phase == 2'h0 ? word[7:0] : phase == 2'h2 ? word[23:16] : word[15:8];
  // low byte ignored by the receiver, so it churns every cycle
  assign pixel_input_bus = stream ? {8'h00, lane, junk} : word;
endmodule : pfu_source

// ---- verification/tb_pixel_input_format_unpacker.sv ----
`timescale 1ns/1ps
`include "pfu_params.svh"
module tb_pixel_input_format_unpacker;
  logic        clock = 1'h0;
  logic        resetn = 1'h0;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, rd0;
  logic        pready, pslverr, err, pixel_valid, stream = 1'h0;
  logic [2:0]  ocs = 3'h0;
  logic        oml = 1'h0, omm = 1'h0;
  logic [23:0] word = 24'h0, pixel_input_bus, ref24;
  logic [7:0]  y_out, cb_out, cr_out, py, pb, pr;
  int          failures = 0, num_checks = 0;

  always #20 clock = ~clock;

  pfu_unpacker u_dut (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pixel_input_bus(pixel_input_bus), .overlay_color_select(ocs),
    .overlay_mix_level_lsb(oml), .overlay_mix_level_msb(omm), .y_out(y_out),
    .cb_out(cb_out), .cr_out(cr_out), .pixel_valid(pixel_valid));
  pfu_source u_src (.clock(clock), .resetn(resetn), .stream(stream), .word(word),
    .pixel_input_bus(pixel_input_bus));

  task end_sim;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'b1) begin
      failures++;
      end_sim();
    end
  endtask : apb

  // write control, then present the pattern and take one settled pixel
  task run(input logic [31:0] c, input logic [23:0] w, input logic s);
    int n;
    apb(1'h1, `PFU_CTRL_OFS, c);
    word   <= w;
    stream <= s;
    repeat (12) @(posedge clock);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pixel_valid !== 1'b1 && n < 50);
    py = y_out;
    pb = cb_out;
    pr = cr_out;
    if (pixel_valid !== 1'b1) begin
      failures++;
      end_sim();
    end
  endtask : run

  initial begin
    repeat (10) @(posedge clock);
    chk({24'h0, y_out}, 32'h0);
    chk({24'h0, cb_out}, 32'h80);
    chk({24'h0, cr_out}, 32'h80);
    chk({31'h0, pixel_valid}, 32'h0);
    resetn <= 1'h1;
    apb(1'h0, `PFU_CTRL_OFS, 32'h0);
    chk(rd, {25'h0, `PFU_CTRL_RST});
    chk({31'h0, err}, 32'h0);
    apb(1'h1, 12'h008, 32'hFFFFFFFF);
    chk({31'h0, err}, 32'h1);
    apb(1'h0, 12'h008, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    run(32'h60, 24'hA5EE05, 1'h0);
    chk({8'h0, py, pb, pr}, 32'h00EE0505);
    apb(1'h0, `PFU_CTRL_OFS, 32'h0);
    chk(rd, 32'h60);
    // color one at full weight is the blue palette entry
    ocs <= 3'h1;
    oml <= 1'h1;
    omm <= 1'h1;
    run(32'h00, 24'hA5EE05, 1'h0);
    chk({8'h0, py, pb, pr}, 32'h00EE0505);
    run(32'h20, 24'hA5EE05, 1'h0);
    chk({8'h0, py, pb, pr}, {8'h0, `PFU_BLUE_Y, `PFU_BLUE_CB, `PFU_BLUE_CR});
    oml <= 1'h0;
    omm <= 1'h0;
    run(32'h20, 24'hA5EE05, 1'h0);
    chk({8'h0, py, pb, pr}, 32'h00EE0505);
    ocs <= 3'h0;
    run(32'h61, 24'h33C45A, 1'h0);
    chk({8'h0, py, pb, pr}, 32'h00C4C4C4);
    ocs <= 3'h7;
    oml <= 1'h1;
    omm <= 1'h1;
    run(32'h62, 24'hF5EE11, 1'h1);
    chk({8'h0, py, pb, pr}, 32'h00EE11F5);
    run(32'h64, 24'h804020, 1'h0);
    ref24 = {py, pb, pr};
    ocs <= 3'h0;
    run(32'h63, 24'h008204, 1'h0);
    chk({8'h0, py, pb, pr}, {8'h0, ref24});
    run(32'h6B, 24'h008204, 1'h0);
    num_checks++;
    if ({py, pb, pr} === ref24) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, {py, pb, pr}, ~ref24);
    end
    run(32'h70, 24'h123456, 1'h0);
    chk({8'h0, py, pb, pr}, {8'h0, `PFU_BLUE_Y, `PFU_BLUE_CB, `PFU_BLUE_CR});
    // reads four clocks apart span two pixels at the steady rate
    apb(1'h0, `PFU_STAT_OFS, 32'h0);
    rd0 = rd;
    apb(1'h0, `PFU_STAT_OFS, 32'h0);
    chk(rd - rd0, 32'h2);
    end_sim();
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge clock);
    failures++;
    end_sim();
  end
endmodule : tb_pixel_input_format_unpacker
